/* File: rtl/cgos_pkg.sv */
// Constants for the clock gating and oscillator stabilization controller.
// Assumes a single main clock domain; wake and reset sources come from outside.
package cgos_pkg;
	// Timebase timer width and the two selectable overflow taps
	localparam int TBT_WIDTH = 18;
	localparam int STAB_TAP_SHORT = 13;
	localparam int STAB_TAP_LONG = 17;
	// Main clock periods per instruction cycle
	localparam int INST_DIV = 4;
	// Timebase timer runs at main clock divided by this
	localparam int TBT_DIV = 2;
	// Reset value of the two select bits (build option)
	localparam logic [1:0] STAB_SEL_RST = 2'h1;
	// Software or watchdog reset length, in instruction cycles
	localparam int INT_RST_INST = 4;
	typedef enum logic [1:0] {
		CGOS_RUN,
		CGOS_SLEEP,
		CGOS_STOP,
		CGOS_STAB
	} cgos_state_t;
endpackage : cgos_pkg

/* File: rtl/cgos_ctrl.sv */
// Clock controller: run, sleep and stop gating with oscillator stabilization delay.
// Assumes the oscillator clock I_CLK keeps toggling in simulation; enables model gating.
// Contract
// RULE_01 - Timebase timer advances once every two main clock periods.
// RULE_02 - Instruction cycle enable pulses once every four main clock periods.
// RULE_03 - CPU and peripheral clock enables follow run, sleep or stop mode.
// RULE_04 - Oscillator enable is low in stop mode, high again on exit.
// RULE_05 - CPU clock held off while the stabilization stop signal is asserted.
// RULE_06 - No CPU or peripheral clock until stabilization delay elapses.
// RULE_07 - Delay clears timebase timer, counts up, ends at chosen bit overflow.
// RULE_08 - Selector chooses one of exactly two timebase-derived durations.
// RULE_09 - Interrupt wake from stop uses build-time chosen delay option.
// RULE_10 - Select bits reset to a build-time constant, not software.
// RULE_11 - Power-on option adds delay at power-up and reset stop exit.
// RULE_12 - Timebase and free-run divided clocks ignore CPU speed shift.
// RULE_13 - Sleep stops CPU and watchdog clocks, other peripherals keep running.
// RULE_14 - Software or watchdog reset in run inserts no delay.
// RULE_15 - Both overflow tap positions are module parameters.
`timescale 1ns/1ps
`default_nettype none
module cgos_ctrl
	import cgos_pkg::*;
#(
	// RULE_15 tap parameters
	parameter int TAP_SHORT = STAB_TAP_SHORT,
	parameter int TAP_LONG = STAB_TAP_LONG,
	parameter bit POR_OPTION = 1'b1,
	parameter logic [1:0] SEL_RESET = STAB_SEL_RST,
	parameter bit WAKE_SEL_LONG = 1'b1
) (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic I_STOP_REQ,
	input wire logic I_SLEEP_REQ,
	input wire logic I_EXT_RESET,
	input wire logic I_EXT_IRQ,
	input wire logic I_PERIPH_IRQ,
	input wire logic I_INT_RESET,
	input wire logic [1:0] I_SPEED_SHIFT,
	output logic O_OSC_EN,
	output logic O_CPU_CLK_EN,
	output logic O_WDT_CLK_EN,
	output logic O_PERIPH_CLK_EN,
	output logic O_TBT_TICK,
	output logic O_INST_TICK,
	output logic O_STAB_STOP,
	output logic O_RESET_HOLD,
	output logic [1:0] O_STAB_SEL,
	output logic [TBT_WIDTH-1:0] O_TBT_COUNT
);
	cgos_state_t state;
	logic [2:0] ext_rst_sync;
	logic [2:0] ext_irq_sync;
	logic ext_rst;
	logic ext_irq;
	logic tbt_phase;
	logic [1:0] inst_cnt;
	logic [TBT_WIDTH-1:0] tbt;
	logic [TBT_WIDTH-1:0] next_tbt;
	logic [1:0] stab_sel;
	logic stab_done;
	logic from_reset;

	// Pin inputs: three stages, change accepted when last two agree
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ext_rst_sync <= 3'h0;
			ext_irq_sync <= 3'h0;
			ext_rst <= 1'b0;
			ext_irq <= 1'b0;
		end else begin
			ext_rst_sync <= {ext_rst_sync[1:0], I_EXT_RESET};
			ext_irq_sync <= {ext_irq_sync[1:0], I_EXT_IRQ};
			if (ext_rst_sync[2] == ext_rst_sync[1]) begin
				ext_rst <= ext_rst_sync[2];
			end
			if (ext_irq_sync[2] == ext_irq_sync[1]) begin
				ext_irq <= ext_irq_sync[2];
			end
		end
	end

	// RULE_01 divide by two for timebase
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tbt_phase <= 1'b0;
		end else if (state == CGOS_STOP) begin
			tbt_phase <= 1'b0;
		end else begin
			tbt_phase <= ~tbt_phase;
		end
	end
	assign O_TBT_TICK = tbt_phase;

	// RULE_02 instruction cycle of four main clocks
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			inst_cnt <= 2'h0;
		end else if (O_CPU_CLK_EN) begin
			inst_cnt <= inst_cnt + 2'h1;
		end
	end
	assign O_INST_TICK = O_CPU_CLK_EN && (inst_cnt == 2'(INST_DIV - 1));

	// RULE_10 select bits from build option
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			stab_sel <= SEL_RESET;
		end else if (state == CGOS_STOP && ext_irq && !ext_rst) begin
			// RULE_09 interrupt wake option
			stab_sel <= WAKE_SEL_LONG ? 2'h1 : 2'h0;
		end else if (state == CGOS_STOP && ext_rst) begin
			stab_sel <= SEL_RESET;
		end
	end
	assign O_STAB_SEL = stab_sel;

	// RULE_08 one of two taps
	// RULE_07 overflow out of chosen bit
	always_comb begin
		next_tbt = tbt + {{(TBT_WIDTH-1){1'b0}}, 1'b1};
		stab_done = (state == CGOS_STAB) && tbt_phase &&
			(stab_sel[0] ? (&tbt[TAP_LONG:0]) : (&tbt[TAP_SHORT:0]));
	end

	// RULE_12 timebase ignores speed shift input
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tbt <= '0;
		end else if (state == CGOS_STOP) begin
			tbt <= '0;
		end else if (tbt_phase) begin
			tbt <= next_tbt;
		end
	end
	assign O_TBT_COUNT = tbt;

	// Mode sequencing; power-on with option starts in stabilization
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state <= POR_OPTION ? CGOS_STAB : CGOS_RUN;
			from_reset <= 1'b1;
		end else begin
			case (state)
				CGOS_RUN: begin
					// RULE_14 internal reset in run: no delay
					from_reset <= 1'b0;
					if (I_STOP_REQ && !I_PERIPH_IRQ && !ext_irq) begin
						state <= CGOS_STOP;
					end else if (I_SLEEP_REQ && !I_PERIPH_IRQ && !ext_irq) begin
						state <= CGOS_SLEEP;
					end
				end
				CGOS_SLEEP: begin
					if (I_PERIPH_IRQ || ext_irq || ext_rst || I_INT_RESET) begin
						state <= CGOS_RUN;
					end
				end
				CGOS_STOP: begin
					// RULE_11 reset exit delayed only with option
					if (ext_rst) begin
						state <= POR_OPTION ? CGOS_STAB : CGOS_RUN;
						from_reset <= 1'b1;
					end else if (ext_irq) begin
						state <= CGOS_STAB;
						from_reset <= 1'b0;
					end
				end
				CGOS_STAB: begin
					if (stab_done) begin
						state <= CGOS_RUN;
					end
				end
				default: begin
					state <= CGOS_RUN;
				end
			endcase
		end
	end

	// RULE_04 oscillator off in stop
	assign O_OSC_EN = (state != CGOS_STOP);
	// RULE_05 stabilization stop signal
	assign O_STAB_STOP = (state == CGOS_STAB);
	assign O_RESET_HOLD = O_STAB_STOP && from_reset;
	// RULE_03 mode based gating
	// RULE_06 no CPU, watchdog or peripheral clock during delay
	// RULE_13 sleep keeps peripherals only
	assign O_CPU_CLK_EN = (state == CGOS_RUN);
	assign O_WDT_CLK_EN = (state == CGOS_RUN);
	assign O_PERIPH_CLK_EN = (state == CGOS_RUN) || (state == CGOS_SLEEP);

	// Speed shift is accepted for port compatibility only
	logic unused_shift;
	assign unused_shift = ^I_SPEED_SHIFT;

	// RULE_05 CPU clock off during stop signal
	chk_cpu_gated_stab: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		O_STAB_STOP |-> !O_CPU_CLK_EN && !O_PERIPH_CLK_EN)
		else $error("cpu or periph clock during stabilization");
	// RULE_04 oscillator halted in stop
	chk_osc_stop_off: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(state == CGOS_STOP) |-> !O_OSC_EN)
		else $error("oscillator running in stop");
	// RULE_13 sleep gating
	chk_sleep_gating: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(state == CGOS_SLEEP) |-> O_PERIPH_CLK_EN && !O_CPU_CLK_EN && !O_WDT_CLK_EN)
		else $error("sleep gating wrong");
	// RULE_01 timebase half rate
	chk_tbt_half_rate: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(state != CGOS_STOP) && $past(state != CGOS_STOP) && O_TBT_TICK |=> !O_TBT_TICK)
		else $error("timebase tick not divide by two");
	// RULE_02 instruction tick spacing
	chk_inst_spacing: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		O_INST_TICK |=> !O_INST_TICK [*3])
		else $error("instruction tick too frequent");
	// RULE_07 timer cleared in stop
	chk_tbt_cleared: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(state == CGOS_STOP) |=> (O_TBT_COUNT == '0) || (state != CGOS_STOP))
		else $error("timebase not cleared in stop");
	// RULE_07 delay ends at tap overflow
	chk_stab_end: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		O_STAB_STOP && stab_done |=> !O_STAB_STOP && O_CPU_CLK_EN)
		else $error("stabilization did not end at overflow");
	// RULE_09 interrupt wake applies delay
	chk_irq_wake_delay: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(state == CGOS_STOP) && ext_irq && !ext_rst |=> O_STAB_STOP
			&& (O_STAB_SEL == (WAKE_SEL_LONG ? 2'h1 : 2'h0)))
		else $error("interrupt wake without delay");
	// RULE_14 no delay from run
	chk_run_no_stab: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(state == CGOS_RUN) |=> !O_STAB_STOP)
		else $error("delay inserted from run");
endmodule : cgos_ctrl
`default_nettype wire

/* File: tb/cgos_ctrl_tb.sv */
// Self-checking bench for cgos_ctrl: mode gating and stabilization delays.
// Assumes taps shortened to 3 and 5: delays of 32 and 128 clocks.
// A second build covers the no power-on option and the short wake delay.
`timescale 1ns/1ps
`default_nettype none
module cgos_ctrl_tb;
	import cgos_pkg::*;
	localparam int DLY = 2**(5+1)*2;
	localparam int DLY_SHORT = 2**(3+1)*2;
	logic I_CLK = 1'b0;
	logic I_ARST_N = 1'b0;
	logic I_STOP_REQ = 1'b0, I_SLEEP_REQ = 1'b0, I_EXT_RESET = 1'b0, I_EXT_IRQ = 1'b0;
	logic I_PERIPH_IRQ = 1'b0, I_INT_RESET = 1'b0;
	logic [1:0] I_SPEED_SHIFT = 2'h0;
	logic O_OSC_EN, O_CPU_CLK_EN, O_WDT_CLK_EN, O_PERIPH_CLK_EN, O_TBT_TICK, O_INST_TICK;
	logic O_STAB_STOP, O_RESET_HOLD;
	logic [1:0] O_STAB_SEL;
	logic [TBT_WIDTH-1:0] O_TBT_COUNT;
	logic alt_cpu_clk_en, alt_stab_stop;
	logic [1:0] alt_stab_sel;
	int errors = 0;
	int compares = 0;
	always #20 I_CLK = ~I_CLK;
	cgos_ctrl #(.TAP_SHORT(3), .TAP_LONG(5)) u_cgos_ctrl (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
		.I_STOP_REQ(I_STOP_REQ), .I_SLEEP_REQ(I_SLEEP_REQ), .I_EXT_RESET(I_EXT_RESET),
		.I_EXT_IRQ(I_EXT_IRQ), .I_PERIPH_IRQ(I_PERIPH_IRQ), .I_INT_RESET(I_INT_RESET),
		.I_SPEED_SHIFT(I_SPEED_SHIFT), .O_OSC_EN(O_OSC_EN), .O_CPU_CLK_EN(O_CPU_CLK_EN),
		.O_WDT_CLK_EN(O_WDT_CLK_EN), .O_PERIPH_CLK_EN(O_PERIPH_CLK_EN),
		.O_TBT_TICK(O_TBT_TICK), .O_INST_TICK(O_INST_TICK), .O_STAB_STOP(O_STAB_STOP),
		.O_RESET_HOLD(O_RESET_HOLD), .O_STAB_SEL(O_STAB_SEL), .O_TBT_COUNT(O_TBT_COUNT));
	// Other build: no power-on delay, short tap at reset and on interrupt wake
	cgos_ctrl #(.TAP_SHORT(3), .TAP_LONG(5), .POR_OPTION(1'b0), .SEL_RESET(2'h0),
		.WAKE_SEL_LONG(1'b0)) u_cgos_ctrl_alt (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
		.I_STOP_REQ(I_STOP_REQ), .I_SLEEP_REQ(I_SLEEP_REQ), .I_EXT_RESET(I_EXT_RESET),
		.I_EXT_IRQ(I_EXT_IRQ), .I_PERIPH_IRQ(I_PERIPH_IRQ), .I_INT_RESET(I_INT_RESET),
		.I_SPEED_SHIFT(I_SPEED_SHIFT), .O_OSC_EN(), .O_CPU_CLK_EN(alt_cpu_clk_en),
		.O_WDT_CLK_EN(), .O_PERIPH_CLK_EN(), .O_TBT_TICK(), .O_INST_TICK(),
		.O_STAB_STOP(alt_stab_stop), .O_RESET_HOLD(), .O_STAB_SEL(alt_stab_sel),
		.O_TBT_COUNT());
	task end_sim;
		$display("checks %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	// Order: osc, cpu, watchdog, peripheral
	task modes(input logic [3:0] e);
		chk("enables", {28'h0, e}, {28'h0, O_OSC_EN, O_CPU_CLK_EN, O_WDT_CLK_EN, O_PERIPH_CLK_EN});
	endtask : modes
	// One-cycle request: stop, sleep, peripheral irq, internal reset
	task go(input logic [3:0] r);
		@(negedge I_CLK);
		{I_STOP_REQ, I_SLEEP_REQ, I_PERIPH_IRQ, I_INT_RESET} = r;
		@(negedge I_CLK);
		{I_STOP_REQ, I_SLEEP_REQ, I_PERIPH_IRQ, I_INT_RESET} = 4'h0;
	endtask : go
	// Counts stabilization cycles of both builds until the CPU clock returns
	task stab(input string nm, input int exp, input int exp_alt);
		int n;
		int m;
		n = 0;
		m = 0;
		repeat (2000) begin
			@(negedge I_CLK);
			if (O_CPU_CLK_EN === 1'b1)
				break;
			if (O_STAB_STOP === 1'b1)
				n++;
			if (alt_stab_stop === 1'b1)
				m++;
		end
		chk(nm, exp, n);
		chk({nm, "_alt"}, exp_alt, m);
	endtask : stab
	initial begin
		int n;
		int k;
		logic [TBT_WIDTH-1:0] t0;
		repeat (20) @(negedge I_CLK);
		chk("stab_sel", {30'h0, STAB_SEL_RST}, {30'h0, O_STAB_SEL});
		chk("por_hold", 32'h3, {30'h0, O_STAB_STOP, O_RESET_HOLD});
		modes(4'h8);
		chk("alt_sel", 32'h0, {30'h0, alt_stab_sel});
		chk("alt_por_run", 32'h1, {31'h0, alt_cpu_clk_en});
		I_ARST_N = 1'b1;
		// Release lands mid-cycle, so one delay cycle passes before the first count
		stab("por_delay", DLY - 1, 0);
		$display("test power-up done");
		I_SPEED_SHIFT = 2'h3;
		t0 = O_TBT_COUNT;
		n = 0;
		k = 0;
		repeat (40) begin
			@(negedge I_CLK);
			n += O_INST_TICK;
			k += O_TBT_TICK;
		end
		chk("inst_ticks", 10, n);
		chk("tbt_ticks", 20, k);
		chk("tbt_adv", 20, O_TBT_COUNT - t0);
		modes(4'hF);
		$display("test run done");
		go(4'h4);
		modes(4'h9);
		go(4'h2);
		modes(4'hF);
		chk("sleep_wake_stab", 0, O_STAB_STOP);
		go(4'h6);
		modes(4'hF);
		go(4'h1);
		repeat (4) begin
			@(negedge I_CLK);
			chk("int_reset_stab", 0, O_STAB_STOP);
		end
		go(4'h4);
		go(4'h1);
		modes(4'hF);
		chk("int_wake_stab", 0, O_STAB_STOP);
		$display("test sleep done");
		go(4'h8);
		modes(4'h0);
		I_EXT_IRQ = 1'b1;
		stab("irq_delay", DLY, DLY_SHORT);
		I_EXT_IRQ = 1'b0;
		modes(4'hF);
		chk("wake_sel", 32'h1, {30'h0, O_STAB_SEL});
		chk("alt_wake_sel", 32'h0, {30'h0, alt_stab_sel});
		$display("test stop irq done");
		// Let the synced interrupt fall first, else the stop request is refused
		repeat (6) @(negedge I_CLK);
		go(4'h8);
		I_EXT_RESET = 1'b1;
		repeat (6) @(negedge I_CLK);
		I_EXT_RESET = 1'b0;
		repeat (8) @(negedge I_CLK);
		chk("rst_hold", 32'h3, {30'h0, O_STAB_STOP, O_RESET_HOLD});
		chk("alt_rst_run", 32'h1, {31'h0, alt_cpu_clk_en});
		// Ten delay cycles already passed during the pin pulse and the wait
		stab("rst_delay", DLY - 10, 0);
		$display("test stop reset done");
		end_sim();
	end
	initial begin
		#(40 * 5000);
		errors++;
		end_sim();
	end
endmodule : cgos_ctrl_tb
`default_nettype wire
